// >>> design/dtm_defines.vh
`ifndef DTM_DEFINES_VH
`define DTM_DEFINES_VH
// register word addresses
`define DTM_ADDR_CLK 4'h0
`define DTM_ADDR_MOD 4'h1
`define DTM_ADDR_CTL 4'h2
`define DTM_ADDR_TR 4'h3
`define DTM_ADDR_TC 4'h4
`define DTM_ADDR_INTF 4'h5
`define DTM_ADDR_INTE 4'h6
// field positions
`define DTM_CLK_DBG_BIT 8
`define DTM_CLK_DIV_HI 7
`define DTM_CLK_DIV_LO 4
`define DTM_CLK_SRC_HI 1
`define DTM_CLK_SRC_LO 0
`define DTM_CTL_RUN_BIT 8
`define DTM_CTL_PRESET_BIT 1
`define DTM_CTL_EN_BIT 0
// codes and reset values
`define DTM_SRC_INT 2'h0
`define DTM_SRC_LOW 2'h1
`define DTM_SRC_HIGH 2'h2
`define DTM_SRC_EXT 2'h3
`define DTM_DIV_LOW_MAX 4'h8
`define DTM_DIV_LOW_ONE 4'hf
`define DTM_RELOAD_RST 16'hffff
`define DTM_UNMAPPED 32'h0000_0000
`endif

// >>> design/dtm_prescaler.v
`timescale 1ns/10ps
// free running divider, one-cycle tick per selected ratio
module dtm_prescaler #(
    parameter WIDTH = 15
) (
    input wire clock,
    input wire rst,
    input wire run,
    input wire step,
    input wire [3:0] sel,
    output wire tick
);
    reg [WIDTH-1:0] cnt_q;
    // tick on the step that finds all low bits below sel set
    wire [WIDTH:0] mask;
    assign mask = ({{WIDTH{1'b0}}, 1'b1} << sel) - {{WIDTH{1'b0}}, 1'b1};
    assign tick = run && step && ((cnt_q & mask[WIDTH-1:0]) == mask[WIDTH-1:0]);
    always @(posedge clock or posedge rst)
    begin
        if (rst)
            cnt_q <= {WIDTH{1'b0}};
        else if (!run)
            cnt_q <= {WIDTH{1'b0}};
        else if (step)
            cnt_q <= cnt_q + {{(WIDTH-1){1'b0}}, 1'b1};
    end
endmodule

// >>> design/dtm_down_timer.v
// The placing of the registers and the Avalon-MM slave port were decided locally.
`timescale 1ns/10ps
`include "dtm_defines.vh"
// What this block does
// - debug_clock_keep 1 keeps count clock in debug, 0 withholds it
// - clock_divider_sel gives 1/1..1/32768; low-speed up to 1/256, 0xf is 1/1
// - clock_source_sel picks internal, low, high osc, or external input at 1/1
// - a source code for an absent source is refused and not stored
// - one_shot_sel 1 stops after one underflow, 0 repeats
// - run_bit write 1 starts, 0 stops; reads 1 while running
// - one-shot underflow clears run_bit by hardware
// - preset write 1 copies reload into counter; reads 1 while copying
// - channel_enable gates the operating clock into the channel
// - reload_value resets to 0xffff, loaded on preset and underflow
// - count_readback is read-only, resets 0xffff, shows the counter
// - underflow_flag set on underflow, write 1 clears
// - underflow_irq_enable turns underflow interrupts on
// - repeat mode reloads on underflow and keeps counting
// - interrupt request only while flag and enable both set
// - source 0x3 on event channel counts event input rising edges
// - underflow period is reload plus one count clocks
module dtm_down_timer #(
    parameter HAS_EVENT = 1,
    parameter HAS_INT_OSC = 1,
    parameter HAS_LOW_OSC = 1,
    parameter HAS_HIGH_OSC = 1,
    parameter HAS_EXT = 1
) (
    input wire clock,
    input wire rst,
    input wire [3:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output wire avs_waitrequest,
    input wire internal_osc,
    input wire low_speed_osc,
    input wire high_speed_osc,
    input wire external_clock_input,
    input wire event_input,
    input wire debug_mode,
    output wire irq,
    output reg underflow_pulse
);
    // registers
    reg debug_clock_keep_q;
    reg [3:0] clock_divider_sel_q;
    reg [1:0] clock_source_sel_q;
    reg one_shot_sel_q;
    reg run_bit_q;
    reg preset_q;
    reg channel_enable_q;
    reg [15:0] reload_value_q;
    reg [15:0] counter_q;
    reg underflow_flag_q;
    reg underflow_irq_enable_q;
    reg rd_done_q;

    // two-stage synchronisers for the oscillator and pin inputs
    reg [4:0] sync1_q;
    reg [4:0] sync2_q;
    reg [4:0] sync3_q;
    wire [4:0] raw_in;
    assign raw_in = {event_input, external_clock_input, high_speed_osc, low_speed_osc, internal_osc};
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi = gi + 1)
        begin : g_sync
            always @(posedge clock or posedge rst)
            begin
                if (rst)
                begin
                    sync1_q[gi] <= 1'b0;
                    sync2_q[gi] <= 1'b0;
                    sync3_q[gi] <= 1'b0;
                end
                else
                begin
                    sync1_q[gi] <= raw_in[gi];
                    sync2_q[gi] <= sync1_q[gi];
                    sync3_q[gi] <= sync2_q[gi];
                end
            end
        end
    endgenerate
    wire [4:0] rise;
    assign rise = sync2_q & ~sync3_q;
    reg dbg_q1;
    reg dbg_q2;
    always @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            dbg_q1 <= 1'b0;
            dbg_q2 <= 1'b0;
        end
        else
        begin
            dbg_q1 <= debug_mode;
            dbg_q2 <= dbg_q1;
        end
    end

    // source select; oscillators sampled as edges on the system clock
    reg src_edge;
    always @*
    begin
        case (clock_source_sel_q)
            `DTM_SRC_INT: src_edge = rise[0];
            `DTM_SRC_LOW: src_edge = rise[1];
            `DTM_SRC_HIGH: src_edge = rise[2];
            `DTM_SRC_EXT:
            begin
                if (HAS_EVENT != 0)
                    src_edge = rise[4];
                else
                    src_edge = rise[3];
            end
            default: src_edge = 1'b0;
        endcase
    end

    // debug gating and channel clock enable
    wire clk_gate;
    assign clk_gate = channel_enable_q && (debug_clock_keep_q || !dbg_q2);

    // effective ratio, low osc capped and 0xf means 1/1; ext fixed 1/1
    reg [3:0] eff_div;
    always @*
    begin
        eff_div = clock_divider_sel_q;
        if (clock_source_sel_q == `DTM_SRC_EXT)
            eff_div = 4'h0;
        else if (clock_source_sel_q == `DTM_SRC_LOW)
        begin
            if (clock_divider_sel_q == `DTM_DIV_LOW_ONE)
                eff_div = 4'h0;
            else if (clock_divider_sel_q > `DTM_DIV_LOW_MAX)
                eff_div = `DTM_DIV_LOW_MAX;
        end
    end

    // prescaler counts source edges, ticks every 2^eff_div of them
    wire div_tick;
    wire edge_tick;
    reg edge_cnt_en;
    dtm_prescaler #(
        .WIDTH(15)
    ) u_pre (
        .clock(clock),
        .rst(rst),
        .run(edge_cnt_en),
        .step(src_edge),
        .sel(eff_div),
        .tick(div_tick)
    );
    assign edge_tick = div_tick;
    always @*
    begin
        edge_cnt_en = clk_gate && run_bit_q;
    end
    // one count clock per divided edge; stopping clears the phase
    wire count_clk;
    assign count_clk = edge_tick && edge_cnt_en;

    reg src_ok;
    reg [1:0] new_src;
    always @*
    begin
        new_src = avs_writedata[`DTM_CLK_SRC_HI:`DTM_CLK_SRC_LO];
        case (new_src)
            `DTM_SRC_INT: src_ok = (HAS_INT_OSC != 0);
            `DTM_SRC_LOW: src_ok = (HAS_LOW_OSC != 0);
            `DTM_SRC_HIGH: src_ok = (HAS_HIGH_OSC != 0);
            `DTM_SRC_EXT: src_ok = (HAS_EVENT != 0) || (HAS_EXT != 0);
            default: src_ok = 1'b0;
        endcase
    end

    // bus: writes complete at once, reads take one wait cycle
    wire wr_fire;
    wire rd_fire;
    assign avs_waitrequest = avs_read && !rd_done_q;
    assign wr_fire = avs_write;
    // captured in the wait cycle so data stand when waitrequest drops
    assign rd_fire = avs_read && !rd_done_q;
    wire lo_be;
    wire hi_be;
    assign lo_be = avs_byteenable[0];
    assign hi_be = avs_byteenable[1];
    wire wr_clk;
    wire wr_mod;
    wire wr_ctl;
    wire wr_tr;
    wire wr_intf;
    wire wr_inte;
    assign wr_clk = wr_fire && (avs_address == `DTM_ADDR_CLK);
    assign wr_mod = wr_fire && (avs_address == `DTM_ADDR_MOD);
    assign wr_ctl = wr_fire && (avs_address == `DTM_ADDR_CTL);
    assign wr_tr = wr_fire && (avs_address == `DTM_ADDR_TR);
    assign wr_intf = wr_fire && (avs_address == `DTM_ADDR_INTF);
    assign wr_inte = wr_fire && (avs_address == `DTM_ADDR_INTE);

    // enable written with or before run/preset
    wire en_next;
    assign en_next = (wr_ctl && lo_be) ? avs_writedata[`DTM_CTL_EN_BIT] : channel_enable_q;

    wire underflow;
    assign underflow = count_clk && (counter_q == 16'h0000);

    always @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            debug_clock_keep_q <= 1'b0;
            clock_divider_sel_q <= 4'h0;
            clock_source_sel_q <= `DTM_SRC_INT;
            one_shot_sel_q <= 1'b0;
            run_bit_q <= 1'b0;
            preset_q <= 1'b0;
            channel_enable_q <= 1'b0;
            reload_value_q <= `DTM_RELOAD_RST;
            counter_q <= `DTM_RELOAD_RST;
            underflow_flag_q <= 1'b0;
            underflow_irq_enable_q <= 1'b0;
            underflow_pulse <= 1'b0;
            rd_done_q <= 1'b0;
            avs_readdata <= 32'h0000_0000;
        end
        else
        begin
            rd_done_q <= avs_read && !rd_done_q;
            underflow_pulse <= underflow;
            if (wr_clk && hi_be)
                debug_clock_keep_q <= avs_writedata[`DTM_CLK_DBG_BIT];
            if (wr_clk && lo_be)
            begin
                clock_divider_sel_q <= avs_writedata[`DTM_CLK_DIV_HI:`DTM_CLK_DIV_LO];
                if (src_ok)
                    clock_source_sel_q <= new_src;
            end
            if (wr_mod && lo_be)
                one_shot_sel_q <= avs_writedata[0];
            if (wr_ctl && lo_be)
                channel_enable_q <= avs_writedata[`DTM_CTL_EN_BIT];
            if (wr_tr && lo_be)
                reload_value_q[7:0] <= avs_writedata[7:0];
            if (wr_tr && hi_be)
                reload_value_q[15:8] <= avs_writedata[15:8];
            if (wr_inte && lo_be)
                underflow_irq_enable_q <= avs_writedata[0];

            // preset: flag for one cycle while the copy happens
            preset_q <= 1'b0;
            if (preset_q)
                counter_q <= reload_value_q;
            else if (underflow)
                // reload on underflow, period is reload plus one
                counter_q <= reload_value_q;
            else if (count_clk)
                counter_q <= counter_q - 16'h0001;
            if (wr_ctl && lo_be && avs_writedata[`DTM_CTL_PRESET_BIT] && en_next)
                preset_q <= 1'b1;

            if (wr_ctl && hi_be)
                run_bit_q <= avs_writedata[`DTM_CTL_RUN_BIT] && en_next;
            else if (underflow && one_shot_sel_q)
                run_bit_q <= 1'b0;

            if (underflow)
                underflow_flag_q <= 1'b1;
            else if (wr_intf && lo_be && avs_writedata[0])
                underflow_flag_q <= 1'b0;

            if (rd_fire)
            begin
                case (avs_address)
                    `DTM_ADDR_CLK: avs_readdata <= {23'h0, debug_clock_keep_q, clock_divider_sel_q, 2'h0,
                        clock_source_sel_q};
                    `DTM_ADDR_MOD: avs_readdata <= {31'h0, one_shot_sel_q};
                    `DTM_ADDR_CTL: avs_readdata <= {23'h0, run_bit_q, 6'h0, preset_q, channel_enable_q};
                    `DTM_ADDR_TR: avs_readdata <= {16'h0, reload_value_q};
                    `DTM_ADDR_TC: avs_readdata <= {16'h0, counter_q};
                    `DTM_ADDR_INTF: avs_readdata <= {31'h0, underflow_flag_q};
                    `DTM_ADDR_INTE: avs_readdata <= {31'h0, underflow_irq_enable_q};
                    default: avs_readdata <= `DTM_UNMAPPED;
                endcase
            end
        end
    end

    assign irq = underflow_flag_q && underflow_irq_enable_q;
endmodule

// >>> testbench/dtm_down_timer_props.sv
`timescale 1ns/10ps
module dtm_down_timer_props (
    input wire clock,
    input wire rst,
    input wire [3:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    input wire debug_mode,
    input wire irq,
    input wire underflow_pulse
);
    reg keep_q;
    reg en_q;
    reg [2:0] quiet_q;
    wire wr0 = avs_write && avs_byteenable[0];
    wire wr_ie = wr0 && avs_address == 4'h6;
    wire wr_if = wr0 && avs_address == 4'h5;
    // seven idle cycles cover the input synchronisers and the pulse register
    always @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            keep_q <= 1'b0;
            en_q <= 1'b0;
            quiet_q <= 3'h0;
        end
        else
        begin
            if (avs_write && avs_byteenable[1] && avs_address == 4'h0)
                keep_q <= avs_writedata[8];
            if (wr0 && avs_address == 4'h2)
                en_q <= avs_writedata[0];
            if ((debug_mode && !keep_q) || !en_q)
                quiet_q <= (quiet_q == 3'h7) ? quiet_q : quiet_q + 3'h1;
            else
                quiet_q <= 3'h0;
        end
    end
    default clocking @(posedge clock);
    endclocking
    default disable iff (rst);
    chk_write_nowait: assert property (avs_write |-> !avs_waitrequest) else $error("write stalled");
    chk_read_wait: assert property (avs_read && !$past(avs_read) |-> avs_waitrequest) else $error("no wait");
    chk_read_done: assert property (avs_read && avs_waitrequest |=> !avs_waitrequest) else $error("long wait");
    chk_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address > 4'h6
        |-> avs_readdata == 32'h0000_0000) else $error("unmapped data");
    chk_pulse_single: assert property (underflow_pulse |=> !underflow_pulse) else $error("long pulse");
    chk_irq_disable: assert property (wr_ie && !avs_writedata[0] |=> !irq) else $error("irq stays");
    chk_irq_clear: assert property (wr_if && avs_writedata[0] && !underflow_pulse
        |=> !irq || underflow_pulse) else $error("irq not cleared");
    chk_irq_cause: assert property ($rose(irq) |-> underflow_pulse || $past(underflow_pulse) || $past(wr_ie))
        else $error("irq without cause");
    chk_gate_quiet: assert property (quiet_q == 3'h7 |-> !underflow_pulse) else $error("count while gated");
    cover property (underflow_pulse);
    cover property ($rose(irq));
    cover property (quiet_q == 3'h7);
endmodule
bind dtm_down_timer dtm_down_timer_props u_props (.clock(clock), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .debug_mode(debug_mode), .irq(irq),
    .underflow_pulse(underflow_pulse));

// >>> testbench/tb_presettable_down_timer.sv
`timescale 1ns/10ps
module tb_presettable_down_timer;
    reg clock = 1'b0;
    reg rst = 1'b1;
    reg [3:0] adr = 4'h0;
    reg rd = 1'b0;
    reg wr = 1'b0;
    reg [31:0] wd = 32'h0000_0000;
    reg osc = 1'b0;
    reg dbg = 1'b0;
    reg [31:0] got;
    wire [31:0] rdata;
    wire wt;
    wire irq;
    wire ufp;
    integer n_fail = 0;
    integer checked = 0;
    integer gap;
    integer i;
    // one source wave feeds every clock input so any selection counts
    dtm_down_timer u_dut (.clock(clock), .rst(rst), .avs_address(adr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wd), .avs_byteenable(4'hf), .avs_readdata(rdata), .avs_waitrequest(wt),
        .internal_osc(osc), .low_speed_osc(osc), .high_speed_osc(osc), .external_clock_input(osc),
        .event_input(osc), .debug_mode(dbg), .irq(irq), .underflow_pulse(ufp));
    initial
    begin
        forever #10 clock = ~clock;
    end
    always @(posedge clock)
        osc <= ~osc;
    task report_and_stop;
    begin
        $display("checks %0d failures %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    end
    endtask
    task chk(input [31:0] g, input [31:0] e);
    begin
        checked = checked + 1;
        if (g !== e)
        begin
            n_fail = n_fail + 1;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    end
    endtask
    // called right after a rising edge; values read after an edge are those it sampled
    task bus(input w, input [3:0] a, input [31:0] d);
    begin
        adr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        @(posedge clock);
        while (wt)
            @(posedge clock);
        got = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge clock);
    end
    endtask
    task wait_pulse(output integer g);
    begin
        g = 0;
        @(negedge clock);
        while (!ufp && g < 3000)
        begin
            g = g + 1;
            @(negedge clock);
        end
    end
    endtask
    // the first gap after a change may be partial, so the third is judged
    task run_cfg(input [31:0] c, input [31:0] e);
    begin
        bus(1, 4'h0, c);
        wait_pulse(gap);
        wait_pulse(gap);
        wait_pulse(gap);
        chk(gap + 1, e);
    end
    endtask
    initial
    begin
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        for (i = 0; i < 8; i = i + 1)
        begin
            bus(0, i[3:0], 0);
            chk(got, (i == 3 || i == 4) ? 32'h0000_ffff : 32'h0000_0000);
        end
        bus(1, 4'h0, 32'hffff_ffff);
        bus(0, 4'h0, 0);
        chk(got, 32'h0000_01f3);
        bus(1, 4'h4, 0);
        bus(0, 4'h4, 0);
        chk(got, 32'h0000_ffff);
        bus(1, 4'h2, 32'h0000_0100);
        bus(0, 4'h2, 0);
        chk(got, 32'h0000_0000);
        bus(1, 4'h3, 32'h0000_0003);
        bus(1, 4'h2, 32'h0000_0003);
        bus(0, 4'h4, 0);
        chk(got, 32'h0000_0003);
        bus(0, 4'h2, 0);
        chk(got, 32'h0000_0001);
        bus(1, 4'h2, 32'h0000_0101);
        bus(0, 4'h2, 0);
        chk(got, 32'h0000_0101);
        run_cfg(32'h0000_0000, 8);
        run_cfg(32'h0000_0010, 16);
        run_cfg(32'h0000_0022, 32);
        run_cfg(32'h0000_00f1, 8);
        run_cfg(32'h0000_0091, 2048);
        run_cfg(32'h0000_0003, 8);
        bus(0, 4'h5, 0);
        chk(got, 32'h0000_0001);
        chk({31'h0, irq}, 32'h0000_0000);
        bus(1, 4'h6, 32'h0000_0001);
        @(negedge clock);
        chk({31'h0, irq}, 32'h0000_0001);
        bus(1, 4'h2, 32'h0000_0001);
        bus(1, 4'h5, 32'h0000_0001);
        @(negedge clock);
        chk({31'h0, irq}, 32'h0000_0000);
        bus(1, 4'h0, 0);
        bus(1, 4'h1, 32'h0000_0001);
        bus(1, 4'h2, 32'h0000_0103);
        wait_pulse(gap);
        bus(0, 4'h2, 0);
        chk(got, 32'h0000_0001);
        bus(0, 4'h4, 0);
        chk(got, 32'h0000_0003);
        wait_pulse(gap);
        chk(gap, 3000);
        bus(1, 4'h1, 0);
        dbg <= 1'b1;
        bus(1, 4'h2, 32'h0000_0101);
        wait_pulse(gap);
        chk(gap, 3000);
        run_cfg(32'h0000_0100, 8);
        dbg <= 1'b0;
        bus(1, 4'h6, 0);
        bus(1, 4'h2, 0);
        report_and_stop;
    end
    initial
    begin
        #(20 * 40000);
        n_fail = n_fail + 1;
        report_and_stop;
    end
endmodule
